// ==== verilog/mdn_pkg.sv ====
package mdn_pkg;

   // operand and result geometry
   localparam int BASE_W  = 32;
   localparam int GUARD_W = 8;
   localparam int OPND_W  = BASE_W + GUARD_W;
   localparam int RES_W   = 24;
   localparam int FRAC_W  = 16;
   localparam int AMT_W   = 6;
   localparam int TOP_BIT = OPND_W - 1;

   // amount when no bit differs from the sign, and the bias of the scan
   localparam logic [AMT_W-1:0] AMT_ALL_SAME = 6'h1F;
   localparam int               AMT_BIAS     = 30;

   // register byte addresses
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  ADDR_SRC1_WORD  = 8'h00;
   localparam logic [7:0]  ADDR_SRC1_GUARD = 8'h04;
   localparam logic [7:0]  ADDR_SRC2_WORD  = 8'h08;
   localparam logic [7:0]  ADDR_SRC2_GUARD = 8'h0C;
   localparam logic [7:0]  ADDR_DEST_WORD  = 8'h10;
   localparam logic [7:0]  ADDR_DEST_GUARD = 8'h14;
   localparam logic [7:0]  ADDR_CTRL       = 8'h18;
   localparam logic [7:0]  ADDR_STATUS     = 8'h1C;
   localparam logic [7:0]  ADDR_CMD        = 8'h20;
   localparam logic [7:0]  ADDR_AMOUNT     = 8'h24;

   // control register fields
   localparam int CTRL_W              = 4;
   localparam int CTRL_SRC_SEL_BIT    = 0;
   localparam int CTRL_DEST_GUARD_BIT = 1;
   localparam int CTRL_COND_LSB       = 2;
   localparam int COND_W              = 2;
   localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

   // execution condition codes
   localparam logic [COND_W-1:0] COND_ALWAYS   = 2'h0;
   localparam logic [COND_W-1:0] COND_IF_TRUE  = 2'h1;
   localparam logic [COND_W-1:0] COND_IF_FALSE = 2'h2;

   // status register fields
   localparam int ST_SEL     = 0;
   localparam int ST_N       = 1;
   localparam int ST_Z       = 2;
   localparam int ST_V       = 3;
   localparam int ST_GREATER = 4;
   localparam int ST_CS_LSB = 5;
   localparam int CS_W      = 3;
   localparam int FLAG_W    = 5;
   localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h00;
   localparam logic [CS_W-1:0]   CS_RST    = 3'h0;

   // condition selection modes
   localparam logic [CS_W-1:0] CS_CARRY = 3'h0;
   localparam logic [CS_W-1:0] CS_NEG   = 3'h1;
   localparam logic [CS_W-1:0] CS_ZERO  = 3'h2;
   localparam logic [CS_W-1:0] CS_OVF   = 3'h3;
   localparam logic [CS_W-1:0] CS_GREATER = 3'h4;
   localparam logic [CS_W-1:0] CS_GE    = 3'h5;

   localparam int CMD_GO_BIT = 0;

   // selectable flag value for a given mode; unused codes give zero
   function automatic logic mdn_sel_flag(input logic [CS_W-1:0] cs,
                                         input logic            neg,
                                         input logic            zero,
                                         input logic            pos);
      logic f;
      f = 1'b0;
      case (cs)
         CS_NEG:  f = neg;
         CS_ZERO: f = zero;
         CS_GREATER: f = pos;
         CS_GE:   f = ~neg;
         default: f = 1'b0;
      endcase
      return f;
   endfunction : mdn_sel_flag

endpackage : mdn_pkg

// ==== verilog/mdn_core_if.sv ====
`timescale 1ns/10ps
interface mdn_core_if;
   logic [mdn_pkg::OPND_W-1:0]        operand;
   logic signed [mdn_pkg::AMT_W-1:0]  amount;
   logic                              neg;
   logic                              zero;
   logic                              pos;

   modport drive (output operand, input amount, input neg, input zero, input pos);
   modport core  (input operand, output amount, output neg, output zero, output pos);
endinterface : mdn_core_if

// ==== verilog/mdn_msb_core.sv ====
`timescale 1ns/10ps
module mdn_msb_core (
   mdn_core_if.core cif
);
   logic [mdn_pkg::OPND_W-1:0] differs;
   logic [mdn_pkg::AMT_W-1:0]  amt;

   // every bit below the sign is compared with it, guard bits too
   genvar g;
   generate
      for (g = 0; g < mdn_pkg::TOP_BIT; g++) begin : g_diff
         assign differs[g] = cif.operand[g] ^ cif.operand[mdn_pkg::TOP_BIT]; // RQ3
      end
   endgenerate
   assign differs[mdn_pkg::TOP_BIT] = 1'b0;

   // ascending scan so the highest differing bit decides the amount
   always_comb begin
      amt = mdn_pkg::AMT_ALL_SAME; // RQ5
      for (int i = 0; i < mdn_pkg::TOP_BIT; i++) begin
         if (differs[i]) begin
            amt = mdn_pkg::AMT_W'(mdn_pkg::AMT_BIAS - i); // RQ5
         end
      end
   end

   // sign classes feed the condition flags
   assign cif.amount = amt;
   assign cif.neg    = amt[mdn_pkg::AMT_W-1];
   assign cif.zero   = (amt == '0);
   assign cif.pos    = ~amt[mdn_pkg::AMT_W-1] & (amt != '0);
endmodule : mdn_msb_core

// ==== verilog/mdn_unit.sv ====
// Notes on behaviour
// (RQ1) The result is 24 bits: 16 upper base bits plus 8 guard bits, like integer results.
// (RQ2) A destination without guard bits receives only the upper word of the result.
// (RQ3) All 40 source bits, guard bits included, are examined for the amount.
// (RQ4) The amount sits at bit 16 as a signed integer, sign filling bits 31..22 and the guard.
// (RQ5) Amount is 30 minus the top bit differing from bit 39, or +31 if none; range -8..+31.
// (RQ6) The operation runs in the stage shared with memory access, one cycle after issue.
// (RQ7) Unconditional runs update the five flags; conditional runs leave them untouched.
// (RQ8) In carry/borrow mode the selectable flag is cleared.
// (RQ9) In negative mode the selectable flag shows a negative result.
// (RQ10) In zero mode the selectable flag shows a zero result.
// (RQ11) In overflow mode the selectable flag is cleared.
// (RQ12) In greater-than mode the selectable flag shows a positive result.
// (RQ13) In greater-or-equal mode the selectable flag shows a zero or positive result.
// (RQ14) The negative and zero flags follow the negative-mode and zero-mode values.
// (RQ15) The overflow flag is always cleared and the greater flag follows greater-than mode.
// (RQ16) The single source is the first or second source field; the result goes to dest.
// (RQ17) A destination with guard bits gets its lower 16 bits cleared.
`timescale 1ns/10ps
module mdn_unit (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [mdn_pkg::ADDR_W-1:0]    paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   output logic      [mdn_pkg::BASE_W-1:0]    result_word,
   output logic      [mdn_pkg::GUARD_W-1:0]   result_guard,
   output logic                               selectable_cond_flag,
   output logic                               neg_flag,
   output logic                               zero_flag,
   output logic                               ovf_flag,
   output logic                               greater_flag,
   output logic                               op_done
);
   localparam int BW = mdn_pkg::BASE_W;
   localparam int GW = mdn_pkg::GUARD_W;
   localparam int OW = mdn_pkg::OPND_W;
   localparam int AW = mdn_pkg::AMT_W;

   logic [31:0]                   prdata_reg;
   logic                          pready_reg;
   logic                          pslverr_reg;
   logic [BW-1:0]                 src1_word_reg;
   logic [GW-1:0]                 src1_guard_reg;
   logic [BW-1:0]                 src2_word_reg;
   logic [GW-1:0]                 src2_guard_reg;
   logic [BW-1:0]                 dest_word_reg;
   logic [GW-1:0]                 dest_guard_reg;
   logic [mdn_pkg::CTRL_W-1:0]    ctrl_reg;
   logic [mdn_pkg::CS_W-1:0]      cs_reg;
   logic                          sel_flag_reg;
   logic                          n_reg;
   logic                          z_reg;
   logic                          v_reg;
   logic                          greater_reg;
   logic [AW-1:0]                 amount_reg;
   logic                          stage_valid_reg;
   logic [OW-1:0]                 stage_operand_reg;
   logic                          stage_dest_guard_reg;
   logic [mdn_pkg::COND_W-1:0]    stage_cond_reg;
   logic                          op_done_reg;

   logic                          apb_setup;
   logic                          apb_done;
   logic                          wr;
   logic                          addr_hit;
   logic [31:0]                   rd_data;
   logic                          go;
   logic                          cond_ok;
   logic                          write_en;
   logic                          flag_upd;
   logic                          status_wr;
   logic signed [AW-1:0]          amt_now;
   logic [OW-1:0]                 res_full;

   mdn_core_if core_bus ();

   mdn_msb_core u_core (
      .cif (core_bus)
   );

   // apb phases: setup is sampled once, the access completes on pready
   assign apb_setup = psel & ~penable;
   assign apb_done  = psel & penable & pready_reg;
   assign wr        = apb_done & pwrite;
   assign status_wr = wr & (paddr == mdn_pkg::ADDR_STATUS);
   assign go        = wr & (paddr == mdn_pkg::ADDR_CMD) & pwdata[mdn_pkg::CMD_GO_BIT];

   // address decode and read data
   always_comb begin
      addr_hit = 1'b1;
      rd_data  = 32'h0000_0000;
      case (paddr)
         mdn_pkg::ADDR_SRC1_WORD:  rd_data = src1_word_reg;
         mdn_pkg::ADDR_SRC1_GUARD: rd_data = {24'h00_0000, src1_guard_reg};
         mdn_pkg::ADDR_SRC2_WORD:  rd_data = src2_word_reg;
         mdn_pkg::ADDR_SRC2_GUARD: rd_data = {24'h00_0000, src2_guard_reg};
         mdn_pkg::ADDR_DEST_WORD:  rd_data = dest_word_reg;
         mdn_pkg::ADDR_DEST_GUARD: rd_data = {24'h00_0000, dest_guard_reg};
         mdn_pkg::ADDR_CTRL:       rd_data = {28'h000_0000, ctrl_reg};
         mdn_pkg::ADDR_STATUS:     rd_data = {24'h00_0000, cs_reg, greater_reg, v_reg, z_reg,
                                              n_reg, sel_flag_reg};
         mdn_pkg::ADDR_CMD:        rd_data = 32'h0000_0000;
         mdn_pkg::ADDR_AMOUNT:     rd_data = 32'(signed'(amount_reg));
         default:                  addr_hit = 1'b0;
      endcase
   end

   // one wait-free access cycle; answers are registered at the setup edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         pready_reg  <= apb_setup;
         pslverr_reg <= apb_setup & ~addr_hit;
         if (apb_setup && !pwrite) begin
            prdata_reg <= rd_data;
         end
      end
   end

   // source and control registers written only by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src1_word_reg  <= '0;
         src1_guard_reg <= '0;
         src2_word_reg  <= '0;
         src2_guard_reg <= '0;
         ctrl_reg       <= mdn_pkg::CTRL_RST;
         cs_reg         <= mdn_pkg::CS_RST;
      end else if (wr) begin
         case (paddr)
            mdn_pkg::ADDR_SRC1_WORD:  src1_word_reg  <= pwdata;
            mdn_pkg::ADDR_SRC1_GUARD: src1_guard_reg <= pwdata[GW-1:0];
            mdn_pkg::ADDR_SRC2_WORD:  src2_word_reg  <= pwdata;
            mdn_pkg::ADDR_SRC2_GUARD: src2_guard_reg <= pwdata[GW-1:0];
            mdn_pkg::ADDR_CTRL:       ctrl_reg       <= pwdata[mdn_pkg::CTRL_W-1:0];
            mdn_pkg::ADDR_STATUS:     cs_reg <= pwdata[mdn_pkg::ST_CS_LSB +: mdn_pkg::CS_W];
            default: ;
         endcase
      end
   end

   // issue: the operand is captured so later source writes cannot disturb the stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_valid_reg      <= 1'b0;
         stage_operand_reg    <= '0;
         stage_dest_guard_reg <= 1'b0;
         stage_cond_reg       <= mdn_pkg::COND_ALWAYS;
      end else begin
         stage_valid_reg <= go;
         if (go) begin
            stage_operand_reg    <= ctrl_reg[mdn_pkg::CTRL_SRC_SEL_BIT] ?
                                    {src2_guard_reg, src2_word_reg} :
                                    {src1_guard_reg, src1_word_reg}; // RQ16
            stage_dest_guard_reg <= ctrl_reg[mdn_pkg::CTRL_DEST_GUARD_BIT];
            stage_cond_reg       <= ctrl_reg[mdn_pkg::CTRL_COND_LSB +: mdn_pkg::COND_W];
         end
      end
   end

   assign core_bus.operand = stage_operand_reg;
   assign amt_now          = core_bus.amount;

   // execution condition tests the selectable flag; code 3 never executes
   always_comb begin
      case (stage_cond_reg)
         mdn_pkg::COND_ALWAYS:   cond_ok = 1'b1;
         mdn_pkg::COND_IF_TRUE:  cond_ok = sel_flag_reg;
         mdn_pkg::COND_IF_FALSE: cond_ok = ~sel_flag_reg;
         default:                cond_ok = 1'b0;
      endcase
   end

   assign write_en = stage_valid_reg & cond_ok; // RQ6
   assign flag_upd = stage_valid_reg & (stage_cond_reg == mdn_pkg::COND_ALWAYS); // RQ7

   // integer result: signed amount at bit 16, lower bits zero
   assign res_full = {{(mdn_pkg::RES_W - AW){amt_now[AW-1]}}, amt_now,
                      {mdn_pkg::FRAC_W{1'b0}}}; // RQ1 RQ4

   // destination: the stage wins over a software write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dest_word_reg  <= '0;
         dest_guard_reg <= '0;
         amount_reg     <= '0;
      end else if (write_en) begin
         amount_reg <= amt_now;
         if (stage_dest_guard_reg) begin
            dest_guard_reg <= res_full[OW-1:BW]; // RQ4
            dest_word_reg  <= res_full[BW-1:0]; // RQ17
         end else begin
            dest_word_reg[BW-1:mdn_pkg::FRAC_W] <= res_full[BW-1:mdn_pkg::FRAC_W]; // RQ2
         end
      end else if (wr && paddr == mdn_pkg::ADDR_DEST_WORD) begin
         dest_word_reg <= pwdata;
      end else if (wr && paddr == mdn_pkg::ADDR_DEST_GUARD) begin
         dest_guard_reg <= pwdata[GW-1:0];
      end
   end

   // flags: hardware update beats a status write landing in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {greater_reg, v_reg, z_reg, n_reg, sel_flag_reg} <= mdn_pkg::FLAGS_RST;
      end else if (flag_upd) begin
         sel_flag_reg <= mdn_pkg::mdn_sel_flag(cs_reg, core_bus.neg, core_bus.zero,
                                               core_bus.pos); // RQ8 RQ9 RQ10 RQ11 RQ12 RQ13
         n_reg        <= core_bus.neg; // RQ14
         z_reg        <= core_bus.zero; // RQ14
         v_reg        <= 1'b0; // RQ15
         greater_reg  <= core_bus.pos; // RQ15
      end else if (status_wr) begin
         {greater_reg, v_reg, z_reg, n_reg, sel_flag_reg} <= pwdata[mdn_pkg::FLAG_W-1:0];
      end
   end

   // completion pulse, also for a conditional run that was skipped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_done_reg <= 1'b0;
      end else begin
         op_done_reg <= stage_valid_reg;
      end
   end

   assign prdata               = prdata_reg;
   assign pready               = pready_reg;
   assign pslverr              = pslverr_reg;
   assign result_word          = dest_word_reg;
   assign result_guard         = dest_guard_reg;
   assign selectable_cond_flag = sel_flag_reg;
   assign neg_flag             = n_reg;
   assign zero_flag            = z_reg;
   assign ovf_flag             = v_reg;
   assign greater_flag         = greater_reg;
   assign op_done              = op_done_reg;

   // checks on the datapath and flag behaviour
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_stage_timing: assert property ( // RQ6
      go |=> stage_valid_reg ##1 op_done_reg)
      else $error("stage or done pulse not on time");
   a_src_select: assert property ( // RQ16
      go |=> stage_operand_reg == ($past(ctrl_reg[mdn_pkg::CTRL_SRC_SEL_BIT]) ?
             $past({src2_guard_reg, src2_word_reg}) : $past({src1_guard_reg, src1_word_reg})))
      else $error("wrong source operand captured");
   a_all_same: assert property ( // RQ5
      (stage_valid_reg && stage_operand_reg == {OW{stage_operand_reg[OW-1]}}) |-> amt_now == 31)
      else $error("uniform operand did not give +31");
   a_guard_scan: assert property ( // RQ3
      (stage_valid_reg && stage_operand_reg[OW-1] != stage_operand_reg[OW-2]) |-> amt_now == -8)
      else $error("top guard difference did not give -8");
   a_cond_keeps: assert property ( // RQ7
      (stage_valid_reg && stage_cond_reg != mdn_pkg::COND_ALWAYS && !status_wr) |=>
      $stable({sel_flag_reg, n_reg, z_reg, v_reg, greater_reg}))
      else $error("conditional run changed flags");
   a_carry_clear: assert property ( // RQ8
      (flag_upd && cs_reg == mdn_pkg::CS_CARRY) |=> !sel_flag_reg)
      else $error("carry mode flag not cleared");
   a_neg_mode: assert property ( // RQ9
      (flag_upd && cs_reg == mdn_pkg::CS_NEG) |=> sel_flag_reg == $past(amt_now < 0))
      else $error("negative mode flag wrong");
   a_zero_mode: assert property ( // RQ10
      (flag_upd && cs_reg == mdn_pkg::CS_ZERO) |=> sel_flag_reg == $past(amt_now == 0))
      else $error("zero mode flag wrong");
   a_ovf_mode: assert property ( // RQ11
      (flag_upd && cs_reg == mdn_pkg::CS_OVF) |=> !sel_flag_reg && !v_reg)
      else $error("overflow mode flag not cleared");
   a_greater_mode: assert property ( // RQ12
      (flag_upd && cs_reg == mdn_pkg::CS_GREATER) |=> sel_flag_reg == $past(amt_now > 0))
      else $error("greater-than mode flag wrong");
   a_ge_mode: assert property ( // RQ13
      (flag_upd && cs_reg == mdn_pkg::CS_GE) |=> sel_flag_reg == $past(amt_now >= 0))
      else $error("greater-or-equal mode flag wrong");
   a_nz_track: assert property ( // RQ14
      flag_upd |=> n_reg == $past(amt_now < 0) && z_reg == $past(amt_now == 0))
      else $error("negative or zero flag wrong");
   a_vgt_track: assert property ( // RQ15
      flag_upd |=> !v_reg && greater_reg == $past(amt_now > 0))
      else $error("overflow or greater flag wrong");
   a_full_dest: assert property ( // RQ1 RQ4 RQ17
      (write_en && stage_dest_guard_reg) |=> dest_word_reg[15:0] == 16'h0000 &&
      dest_guard_reg == {GW{dest_word_reg[BW-1]}} &&
      $signed(dest_word_reg[BW-1:mdn_pkg::FRAC_W]) == $past(amt_now))
      else $error("full destination layout wrong");
   a_upper_only: assert property ( // RQ2
      (write_en && !stage_dest_guard_reg) |=> $stable(dest_guard_reg) &&
      $stable(dest_word_reg[15:0]) &&
      $signed(dest_word_reg[BW-1:mdn_pkg::FRAC_W]) == $past(amt_now))
      else $error("upper-word-only write wrong");

   c_full_write: cover property (write_en && stage_dest_guard_reg);
   c_skip_run:   cover property (stage_valid_reg && !cond_ok);
   c_min_amount: cover property (write_en && amt_now == -8);
   c_max_amount: cover property (write_en && amt_now == 31);
endmodule : mdn_unit

// ==== testbench/mdn_apb_master.sv ====
`timescale 1ns/10ps
// register file side: speaks apb, one transfer at a time
module mdn_apb_master (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   logic timed_out;

   // idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      timed_out = 1'b0;
   end

   // request held until pready seen high at an edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      timed_out = (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines flip so a stale value cannot pass for a held one
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : mdn_apb_master

// ==== testbench/tb.sv ====
`timescale 1ns/10ps
module tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr, result_guard;
   logic [31:0] pwdata, prdata, result_word, rd;
   logic        selectable_cond_flag, neg_flag, zero_flag, ovf_flag, greater_flag, op_done;
   int          failures, check_count;

   mdn_unit i_mdn_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .result_word(result_word), .result_guard(result_guard),
      .selectable_cond_flag(selectable_cond_flag), .neg_flag(neg_flag),
      .zero_flag(zero_flag), .ovf_flag(ovf_flag), .greater_flag(greater_flag),
      .op_done(op_done));
   mdn_apb_master i_mdn_apb_master (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   // 40 mhz clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic summarize();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // a hung transfer ends the run at once
   task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
      i_mdn_apb_master.xfer(w, a, d, rd, err);
      if (i_mdn_apb_master.timed_out !== 1'b0) begin
         failures++;
         summarize();
      end
   endtask : xf

   // expected amount: 30 minus top bit differing from bit 39, else 31
   function automatic int exp_amt(input logic [39:0] x);
      int a;
      a = 31;
      for (int i = 0; i <= 38; i++) if (x[i] != x[39]) a = 30 - i;
      return a;
   endfunction : exp_amt

   task automatic run(input logic [39:0] x, input logic [3:0] ctrl, input logic [7:0] st);
      int n;
      xf(1'b1, ctrl[0] ? mdn_pkg::ADDR_SRC2_WORD : mdn_pkg::ADDR_SRC1_WORD, x[31:0]);
      xf(1'b1, ctrl[0] ? mdn_pkg::ADDR_SRC2_GUARD : mdn_pkg::ADDR_SRC1_GUARD, {24'h0, x[39:32]});
      xf(1'b1, mdn_pkg::ADDR_CTRL, {28'h0, ctrl});
      xf(1'b1, mdn_pkg::ADDR_STATUS, {24'h0, st});
      xf(1'b1, mdn_pkg::ADDR_CMD, 32'h1);
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (op_done !== 1'b1 && n < 8);
      if (op_done !== 1'b1) begin
         failures++;
         summarize();
      end
   endtask : run

   task automatic t_reset();
      chk(result_word, 32'h0, "word after reset");
      chk({greater_flag, ovf_flag, zero_flag, neg_flag, selectable_cond_flag}, 0, "flags");
      xf(1'b0, mdn_pkg::ADDR_STATUS, 32'h0);
      chk(rd, 32'h0, "status reset");
      xf(1'b0, 8'h40, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped error");
      chk(rd, 32'h0, "unmapped read");
   endtask : t_reset

   // every mode of the selectable flag, across the whole amount range
   task automatic t_modes();
      logic [39:0] ops [10];
      int          a;
      logic [31:0] e;
      logic        exp_sel;
      ops = '{40'h0, 40'h1, 40'h00_4000_0000, 40'h00_8000_0000, 40'h40_0000_0000,
              40'h80_0000_0000, 40'hFF_FFFF_FFFE, 40'hFF_FFFF_FFFF, 40'h00_0001_0000,
              40'hFF_7FFF_FFFF};
      for (int i = 0; i < 10; i++) begin
         a = exp_amt(ops[i]);
         e = a;
         exp_sel = (i % 8 == 1) ? a < 0 : (i % 8 == 2) ? a == 0 : (i % 8 == 4) ? a > 0 :
              (i % 8 == 5) ? a >= 0 : 1'b0;
         run(ops[i], 4'h2, {i[2:0], 5'h1F});
         chk(result_word, {e[15:0], 16'h0}, "word");
         chk(result_guard, {8{e[31]}}, "guard");
         chk({greater_flag, ovf_flag, zero_flag, neg_flag, selectable_cond_flag},
             {a > 0, 1'b0, a == 0, a < 0, exp_sel}, "flags");
         xf(1'b0, mdn_pkg::ADDR_AMOUNT, 32'h0);
         chk(rd, e, "amount");
      end
   endtask : t_modes

   // second source into a destination without guard bits
   task automatic t_noguard();
      xf(1'b1, mdn_pkg::ADDR_DEST_WORD, 32'h1234_5678);
      xf(1'b1, mdn_pkg::ADDR_DEST_GUARD, 32'hA5);
      run(40'h00_0000_8000, 4'h1, 8'h00);
      chk(result_word, 32'h000F_5678, "upper word only");
      chk({24'h0, result_guard}, 32'hA5, "guard kept");
   endtask : t_noguard

   // conditional runs must leave the flags alone
   task automatic t_cond();
      run(40'h1, 4'h6, 8'h41);
      chk(result_word, 32'h001E_0000, "cond true word");
      chk({greater_flag, zero_flag, selectable_cond_flag}, 3'h1, "cond flags");
      run(40'h0, 4'hE, 8'h41);
      chk(result_word, 32'h001E_0000, "never word");
      chk({greater_flag, zero_flag, selectable_cond_flag}, 3'h1, "never flags");
      // run-if-clear code: executes with the flag low, skips with it high
      run(40'h0, 4'hA, 8'h40);
      chk(result_word, 32'h001F_0000, "if-clear word");
      chk({greater_flag, zero_flag, selectable_cond_flag}, 3'h0, "if-clear flags");
      run(40'h1, 4'hA, 8'h41);
      chk(result_word, 32'h001F_0000, "skip word");
      chk({greater_flag, zero_flag, selectable_cond_flag}, 3'h1, "skip flags");
   endtask : t_cond

   // reset for two cycles, then the scenarios
   initial begin
      failures = 0;
      check_count = 0;
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_modes();
      t_noguard();
      t_cond();
      summarize();
   end
endmodule : tb
